/* logic/srd_pkg.sv */
// Constants, register map and row-order decoding for the row-scan driver
package srd_pkg;

  localparam int unsigned NUM_ROWS   = 40;
  localparam int unsigned HALF_ROWS  = 20;
  localparam int unsigned ROW_IDX_W  = 6;

  localparam int unsigned APB_AW     = 12;
  localparam int unsigned APB_DW     = 32;

  // Register byte offsets
  localparam logic [APB_AW-1:0] CTRL_OFFS    = 12'h000;
  localparam logic [APB_AW-1:0] STAGE_LO_OFFS = 12'h004;
  localparam logic [APB_AW-1:0] STAGE_HI_OFFS = 12'h008;

  // Control register fields
  localparam int unsigned CTRL_DIR_BIT   = 0;
  localparam int unsigned CTRL_SPLIT_BIT = 1;
  localparam int unsigned CTRL_SENSE_BIT = 2;
  localparam int unsigned CTRL_GATE_BIT  = 3;
  localparam int unsigned CTRL_W         = 4;
  // Reset: descending, no split, drive high, row outputs gated off
  localparam logic [CTRL_W-1:0] CTRL_RESET = 4'hC;

  // Stage-high register fields
  localparam int unsigned STAGE_HI_W      = 8;
  localparam int unsigned STAGE_CASC_BIT  = 8;

  // Position in the scan order of physical row r (0-based) for each mode
  function automatic logic [ROW_IDX_W-1:0] stage_of_row(input int unsigned r,
                                                        input logic dir,
                                                        input logic split);
    int unsigned k;
    k = 0;
    if (!split) begin
      k = dir ? r : (NUM_ROWS - 1 - r);
    end else if (dir) begin
      k = (r >= HALF_ROWS) ? (r - HALF_ROWS) : (r + HALF_ROWS);
    end else begin
      k = (r < HALF_ROWS) ? (HALF_ROWS - 1 - r) : (NUM_ROWS + HALF_ROWS - 1 - r);
    end
    return k[ROW_IDX_W-1:0];
  endfunction : stage_of_row

endpackage : srd_pkg

/* logic/srd_scan_if.sv */
// Signals shared between the driver top and its scan chain
interface srd_scan_if;
  import srd_pkg::*;

  logic                shift_en;
  logic                token_in;
  logic [NUM_ROWS-1:0] stages;

  modport ctrl  (output shift_en, output token_in, input stages);
  modport chain (input shift_en, input token_in, output stages);
endinterface : srd_scan_if

/* logic/srd_scan_chain.sv */
// Forty-stage token shift register held in scan order
module srd_scan_chain
  import srd_pkg::*;
(
  input  wire logic  core_clk_i,
  input  wire logic  srst_i,
  srd_scan_if.chain  scan
);

  logic [NUM_ROWS-1:0] stage_q;
  logic [NUM_ROWS-1:0] next_stage;

  // A token on the input wipes the chain and restarts one bit at the head
  assign next_stage = scan.token_in ? {{(NUM_ROWS-1){1'b0}}, 1'b1}
                                    : {stage_q[NUM_ROWS-2:0], 1'b0};

  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      stage_q <= '0;
    end else if (scan.shift_en) begin
      stage_q <= next_stage;
    end
  end

  assign scan.stages = stage_q;

endmodule : srd_scan_chain

/* logic/srd_row_driver.sv */
// Row-scan driver top: shift-clock edge detect, token ports, row outputs, APB
//
// The APB slave port and the placing of the registers were left to the implementer.
module srd_row_driver
  import srd_pkg::*;
#(
  parameter int unsigned ROWS = NUM_ROWS
) (
  input  wire logic                core_clk_i,
  input  wire logic                srst_i,
  // Shift clock and token pins from the timing controller
  input  wire logic                shift_clk_i,
  input  wire logic                token_port_a_i,
  output logic                     token_port_a_o,
  output logic                     token_port_a_oe_o,
  input  wire logic                token_port_b_i,
  output logic                     token_port_b_o,
  output logic                     token_port_b_oe_o,
  // Row outputs, each a level plus an output enable
  output logic [ROWS-1:0]          row_drive_lines_o,
  output logic [ROWS-1:0]          row_drive_lines_oe_o,
  // APB slave
  input  wire logic                psel_i,
  input  wire logic                penable_i,
  input  wire logic                pwrite_i,
  input  wire logic [APB_AW-1:0]   paddr_i,
  input  wire logic [APB_DW-1:0]   pwdata_i,
  input  wire logic [3:0]          pstrb_i,
  output logic [APB_DW-1:0]        prdata_o,
  output logic                     pready_o,
  output logic                     pslverr_o
);

  // Control register
  logic [CTRL_W-1:0] ctrl_q;
  logic              scan_dir;
  logic              split_scan;
  logic              drive_sense_n;
  logic              out_gate_n;

  assign scan_dir      = ctrl_q[CTRL_DIR_BIT];
  assign split_scan    = ctrl_q[CTRL_SPLIT_BIT];
  assign drive_sense_n = ctrl_q[CTRL_SENSE_BIT];
  assign out_gate_n    = ctrl_q[CTRL_GATE_BIT];

  // Shift clock edges
  // Pins are synchronous to core_clk_i, so one delay stage is enough
  logic shift_clk_q;
  wire  shift_rise = shift_clk_i & ~shift_clk_q;
  wire  shift_fall = ~shift_clk_i & shift_clk_q;

  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      shift_clk_q <= 1'b0;
    end else begin
      shift_clk_q <= shift_clk_i;
    end
  end

  // Scan chain
  srd_scan_if scan_bus ();

  wire token_in = scan_dir ? token_port_a_i : token_port_b_i;

  assign scan_bus.shift_en = shift_rise;
  assign scan_bus.token_in = token_in;

  srd_scan_chain u_chain (
    .core_clk_i (core_clk_i),
    .srst_i     (srst_i),
    .scan       (scan_bus.chain)
  );

  wire [NUM_ROWS-1:0] stages = scan_bus.stages;

  // Cascade token
  // Last stage is copied out at the falling edge, half a shift period late,
  // so the next device sees stable data around its own rising edge.
  logic cascade_q;

  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      cascade_q <= 1'b0;
    end else if (shift_fall) begin
      cascade_q <= stages[NUM_ROWS-1];
    end
  end

  // Cascade is a push-pull buffer on whichever port is not the input
  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      token_port_a_o    <= 1'b0;
      token_port_a_oe_o <= 1'b0;
      token_port_b_o    <= 1'b0;
      token_port_b_oe_o <= 1'b0;
    end else begin
      token_port_a_o    <= ~scan_dir & cascade_q;
      token_port_a_oe_o <= ~scan_dir;
      token_port_b_o    <= scan_dir & cascade_q;
      token_port_b_oe_o <= scan_dir;
    end
  end

  // Row mapping and output stage
  logic [ROWS-1:0] row_bit;
  logic [ROWS-1:0] next_row_level;
  logic [ROWS-1:0] next_row_oe;

  genvar r;
  generate
    for (r = 0; r < ROWS; r++) begin : g_row
      wire [ROW_IDX_W-1:0] stage_idx = stage_of_row(r, scan_dir, split_scan);
      assign row_bit[r]        = stages[stage_idx];
      assign next_row_oe[r]    = ~out_gate_n & row_bit[r];
      assign next_row_level[r] = next_row_oe[r] & drive_sense_n;
    end
  endgenerate

  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      row_drive_lines_o    <= '0;
      row_drive_lines_oe_o <= '0;
    end else begin
      row_drive_lines_o    <= next_row_level;
      row_drive_lines_oe_o <= next_row_oe;
    end
  end

  // APB slave
  // Ready is registered: every access phase lasts exactly two cycles
  wire access    = psel_i & penable_i & ~pready_o;
  wire hit_ctrl  = (paddr_i == CTRL_OFFS);
  wire hit_lo    = (paddr_i == STAGE_LO_OFFS);
  wire hit_hi    = (paddr_i == STAGE_HI_OFFS);
  wire hit_any   = hit_ctrl | hit_lo | hit_hi;
  wire ctrl_wr   = access & pwrite_i & hit_ctrl & pstrb_i[0];

  logic [APB_DW-1:0] read_mux;

  assign read_mux =
      hit_ctrl ? {{(APB_DW-CTRL_W){1'b0}}, ctrl_q} :
      hit_lo   ? stages[APB_DW-1:0] :
      hit_hi   ? {{(APB_DW-STAGE_CASC_BIT-1){1'b0}}, cascade_q,
                  stages[NUM_ROWS-1:NUM_ROWS-STAGE_HI_W]} :
                 {APB_DW{1'b0}};

  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      ctrl_q <= CTRL_RESET;
    end else if (ctrl_wr) begin
      ctrl_q <= pwdata_i[CTRL_W-1:0];
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      pready_o  <= 1'b0;
      pslverr_o <= 1'b0;
      prdata_o  <= '0;
    end else begin
      pready_o  <= access;
      pslverr_o <= access & ~hit_any;
      prdata_o  <= (access & ~pwrite_i) ? read_mux : {APB_DW{1'b0}};
    end
  end

endmodule : srd_row_driver

/* dv/srd_row_driver_chk.sv */
// Port-level assertions for the row-scan driver
module srd_row_driver_chk
  import srd_pkg::*;
#(
  parameter int unsigned ROWS = NUM_ROWS
) (
  input wire logic            core_clk_i,
  input wire logic            srst_i,
  input wire logic            shift_clk_i,
  input wire logic            token_port_a_oe_o,
  input wire logic            token_port_b_o,
  input wire logic            token_port_b_oe_o,
  input wire logic [ROWS-1:0] row_drive_lines_o,
  input wire logic [ROWS-1:0] row_drive_lines_oe_o,
  input wire logic            psel_i,
  input wire logic            penable_i,
  input wire logic            pready_o,
  input wire logic            pslverr_o
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (srst_i);
  // Four quiet samples cover the two-cycle lag from a shift edge or write to the rows
  sequence quiet_s;
    (!psel_i && $stable(shift_clk_i)) [*4];
  endsequence
  sequence fell_s;
    $past(shift_clk_i, 3) && !$past(shift_clk_i, 2);
  endsequence
  oe_excl_a: assert property (!(token_port_a_oe_o && token_port_b_oe_o))
    else $error("both token ports driven");
  row_lvl_a: assert property ((row_drive_lines_o & ~row_drive_lines_oe_o) == '0)
    else $error("row level on a row in high-Z");
  token_one_a: assert property ($onehot0(row_drive_lines_oe_o))
    else $error("more than one row driven");
  rows_hold_a: assert property (quiet_s |-> $stable(row_drive_lines_oe_o))
    else $error("rows moved without a shift edge");
  casc_fall_a: assert property ($changed(token_port_b_o) && token_port_b_oe_o
    && $stable(token_port_b_oe_o) |-> fell_s)
    else $error("cascade changed away from a falling edge");
  rdy_pulse_a: assert property (pready_o |=> !pready_o)
    else $error("ready longer than one cycle");
  rdy_wait_a: assert property (psel_i && penable_i && !pready_o |=> pready_o)
    else $error("ready late");
  err_rdy_a: assert property (pslverr_o |-> pready_o && psel_i)
    else $error("error without ready");
endmodule : srd_row_driver_chk

bind srd_row_driver srd_row_driver_chk #(.ROWS(ROWS)) chk_u (
  .core_clk_i(core_clk_i), .srst_i(srst_i), .shift_clk_i(shift_clk_i),
  .token_port_a_oe_o(token_port_a_oe_o), .token_port_b_o(token_port_b_o),
  .token_port_b_oe_o(token_port_b_oe_o), .row_drive_lines_o(row_drive_lines_o),
  .row_drive_lines_oe_o(row_drive_lines_oe_o), .psel_i(psel_i), .penable_i(penable_i),
  .pready_o(pready_o), .pslverr_o(pslverr_o));

/* dv/srd_ctrl_model.sv */
// Timing controller model: shift clock and scan token
module srd_ctrl_model (
  input  wire logic clk_i,
  output logic      shift_clk_o,
  output logic      token_o
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    shift_clk_o = 1'b0;
    token_o     = 1'b0;
  end
  // Token rises with the shift clock and drops only after the low phase
  task automatic step(input logic tok, input int hold);
    @(posedge clk_i);
    shift_clk_o <= 1'b1;
    token_o     <= tok;
    repeat (hold) @(posedge clk_i);
    shift_clk_o <= 1'b0;
    repeat (hold) @(posedge clk_i);
    token_o     <= 1'b0;
  endtask : step
endmodule : srd_ctrl_model

/* dv/srd_row_driver_tb_top.sv */
// Self-checking bench for the row-scan driver
module srd_row_driver_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import srd_pkg::*;
  int                  dir, split, gate, pos, fails, cmp_count, cyc;
  logic                core_clk_i = 1'b0, srst_i = 1'b1, ph = 1'b0;
  logic                psel_i = 1'b0, penable_i = 1'b0, pwrite_i = 1'b0;
  logic [3:0]          pstrb_i = 4'hF;
  logic [APB_AW-1:0]   paddr_i = '0;
  logic [APB_DW-1:0]   pwdata_i = '0, prdata_o, q;
  logic                a_o, a_oe, b_o, b_oe, pready_o, pslverr_o, e, sclk, tok;
  logic [NUM_ROWS-1:0] rows, rows_oe, er;
  // An undriven token pin toggles so a stale level cannot pass
  wire                 a_w = a_oe ? a_o : (dir ? tok : ph);
  wire                 b_w = b_oe ? b_o : (dir ? ph : tok);
  srd_row_driver dut_u (.core_clk_i, .srst_i, .shift_clk_i(sclk), .token_port_a_i(a_w),
    .token_port_a_o(a_o), .token_port_a_oe_o(a_oe), .token_port_b_i(b_w),
    .token_port_b_o(b_o), .token_port_b_oe_o(b_oe), .row_drive_lines_o(rows),
    .row_drive_lines_oe_o(rows_oe), .psel_i, .penable_i, .pwrite_i, .paddr_i, .pwdata_i,
    .pstrb_i, .prdata_o, .pready_o, .pslverr_o);
  srd_ctrl_model ctl_u (.clk_i(core_clk_i), .shift_clk_o(sclk), .token_o(tok));
  always #2.5 core_clk_i = ~core_clk_i;
  always @(posedge core_clk_i) begin
    ph <= ~ph;
    cyc++;
    if (cyc == 20000) begin
      fails++;
      complete_run();
    end
  end
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    cmp_count++;
    if (got !== exp) begin
      fails++;
      $display("wrong value at %0t: got %0h want %0h", $time, got, exp);
    end
  endtask : chk
  task automatic apb(input logic wr, input logic [11:0] ad, input logic [31:0] d);
    psel_i   <= 1'b1;
    pwrite_i <= wr;
    paddr_i  <= ad;
    pwdata_i <= d;
    @(posedge core_clk_i);
    penable_i <= 1'b1;
    do begin
      @(posedge core_clk_i);
    end while (pready_o !== 1'b1);
    q = prdata_o;
    e = pslverr_o;
    psel_i    <= 1'b0;
    penable_i <= 1'b0;
    // One idle edge so a following call never reassigns psel in the same step
    @(posedge core_clk_i);
  endtask : apb
  function automatic int row_of(int k);
    if (!split) return dir ? k : NUM_ROWS - 1 - k;
    if (dir) return k < HALF_ROWS ? k + HALF_ROWS : k - HALF_ROWS;
    return k < HALF_ROWS ? HALF_ROWS - 1 - k : NUM_ROWS + HALF_ROWS - 1 - k;
  endfunction : row_of
  task automatic complete_run();
    $display("%0d compares, %0d mismatches", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : complete_run
  initial begin
    logic sense;
    void'($urandom(95387));
    repeat (2) @(posedge core_clk_i);
    srst_i <= 1'b0;
    @(posedge core_clk_i);
    apb(0, CTRL_OFFS, 0);
    chk(q, 64'(CTRL_RESET));
    apb(0, 12'h00C, 0);
    chk({q, e}, 1);
    $display("register test done");
    // Mode 4 repeats with the gate closed; a second token restarts each scan mid-way
    for (int m = 0; m < 5; m++) begin
      dir   = m % 2;
      split = m / 2 % 2;
      gate  = (m == 4);
      sense = 1'($urandom);
      apb(1, CTRL_OFFS, {28'h0, 1'(gate), sense, 1'(split), 1'(dir)});
      pos = NUM_ROWS;
      for (int i = 0; i < 52; i++) begin
        ctl_u.step(i == 0 || i == 11, 3 + $urandom % 3);
        pos = (i == 0 || i == 11) ? 0 : (pos < NUM_ROWS ? pos + 1 : pos);
        er  = (pos < NUM_ROWS && gate == 0) ? 40'h1 << row_of(pos) : '0;
        #1;
        chk(rows_oe, er);
        chk(rows, sense ? er : '0);
        chk(dir ? b_o : a_o, pos == NUM_ROWS - 1);
        chk(dir ? b_oe : a_oe, 1);
        chk(dir ? a_oe : b_oe, 0);
        @(posedge core_clk_i);
        apb(0, STAGE_LO_OFFS, 0);
        chk(q, pos < 32 ? 32'h1 << pos : 0);
        apb(0, STAGE_HI_OFFS, 0);
        chk(q, {pos == NUM_ROWS - 1, 8'(pos > 31 ? 1 << (pos - 32) : 0)});
      end
      $display("mode %0d done, %0d mismatches", m, fails);
    end
    complete_run();
  end
endmodule : srd_row_driver_tb_top
